// >>> bgc_pkg.sv
/*
  Constants shared by the busy and gate control logic: register map,
  status fields, interrupt events and timing counts.
  Assumes a 125 MHz reference clock and a plain register port.
*/
// Notes on behaviour
// - Busy while converting, resetting, testing, buffer full
// - Own busy shown in status bit 2
// - Wired OR/NAND busy lines; line in bit 3
// - Channel gates accepted only inside common gate
// - Veto high suppresses conversion of charges
// - Common gate is OR of both gate inputs
// - One individual gate for each of 32 channels
// - Jumper high halts on bus busy, low own
// - Acknowledge LED pulses on every bus access
// - Red busy LED, also during power-on configuration
// - Yellow LED when buffer holds data, configuring
// - Termination LED green, red, off, orange configuring
// - Base address from four rotary switches
// - Busy rises on gate edge, falls at end
// - While busy ignore gates, start nothing new
// - Data ready in status bit 0, drives line
`default_nettype none

package bgc_pkg;

  // Register map (byte addresses)
  localparam logic [7:0] BGC_ADDR_STATUS = 8'h00;
  localparam logic [7:0] BGC_ADDR_CTRL = 8'h04;
  localparam logic [7:0] BGC_ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] BGC_ADDR_INT_MASK = 8'h0c;
  localparam logic [7:0] BGC_ADDR_BASE = 8'h10;

  // Status field positions
  localparam int BGC_ST_DATA_READY_LINE = 0;
  localparam int BGC_ST_DATA_READY_LINE_LINE = 1;
  localparam int BGC_ST_BUSY = 2;
  localparam int BGC_ST_GBUSY = 3;

  // Control field positions and reset value
  localparam int BGC_CTRL_MEMTEST = 0;
  localparam logic [31:0] BGC_CTRL_RESET = 32'h0000_0000;

  // Interrupt events
  localparam int BGC_EV_W = 4;
  localparam int BGC_EV_ACCEPT = 0;
  localparam int BGC_EV_REJECT = 1;
  localparam int BGC_EV_DONE = 2;
  localparam int BGC_EV_DATA_READY_LINE = 3;
  localparam logic [BGC_EV_W-1:0] BGC_MASK_RESET = 4'h0;

  // Channels, termination lines, switches
  localparam int BGC_CHANNELS = 32;
  localparam int BGC_TERM_LINES = 7;
  localparam int BGC_SWITCHES = 4;
  localparam int BGC_SYNC_W = 5;

  // Timing: microsecond tick from the reference clock
  localparam int BGC_CLK_PERIOD_NS = 8;
  localparam int BGC_TICK_NS = 1000;
  localparam int BGC_TICK_CYCLES =
    (BGC_TICK_NS + BGC_CLK_PERIOD_NS - 1) / BGC_CLK_PERIOD_NS;
  localparam int BGC_CFG_TIME_US = 100000;
  localparam int BGC_ACK_TIME_US = 20000;
  localparam int BGC_TIME_W = 17;

endpackage : bgc_pkg

`default_nettype wire

// >>> bgc_sync.sv
/*
  Two-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level; no bus coherence is kept.
*/
`timescale 1ns/1ps
`default_nettype none

module bgc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      stage1 <= '0;
      o_sync <= '0;
    end
    else
    begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule // bgc_sync

`default_nettype wire

// >>> bgc_busy_gate.sv
/*
  Acquisition control: common gate, veto, busy state, wired busy and
  data ready lines, status and interrupt registers, front panel LEDs.
  Assumes the converter reports the end of its sequence with a pulse
  and the bus decoder pulses i_bus_access on each module access.
*/
`timescale 1ns/1ps
`default_nettype none

module bgc_busy_gate
  import bgc_pkg::*;
#(
  parameter int CFG_TIME_US = BGC_CFG_TIME_US,
  parameter int ACK_TIME_US = BGC_ACK_TIME_US
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rd_data,
  output logic o_irq,
  // Gates and veto
  input wire logic i_gate_front,
  input wire logic i_gate_bus,
  input wire logic i_veto,
  input wire logic [BGC_CHANNELS-1:0] i_chan_gate,
  // Wired control bus lines
  input wire logic i_busy_line,
  input wire logic i_data_ready_line_line,
  output logic o_busy_pos,
  output logic o_busy_pos_oe_n,
  output logic o_busy_neg,
  output logic o_busy_neg_oe_n,
  output logic o_data_ready_line_pos,
  output logic o_data_ready_line_pos_oe_n,
  output logic o_data_ready_line_neg,
  output logic o_data_ready_line_neg_oe_n,
  // Converter and buffer
  input wire logic i_conv_done,
  input wire logic i_analog_reset,
  input wire logic i_buffer_full,
  input wire logic i_buffer_has_data,
  output logic o_conv_start,
  output logic o_conv_inhibit,
  output logic [BGC_CHANNELS-1:0] o_chan_integrate,
  // Board settings
  input wire logic i_busy_scope_jumper,
  input wire logic [4*BGC_SWITCHES-1:0] i_rotary_sw,
  input wire logic [BGC_TERM_LINES-1:0] i_term_on,
  input wire logic i_bus_access,
  output logic [4*BGC_SWITCHES-1:0] o_base_addr,
  // Front panel LEDs
  output logic o_led_ack,
  output logic o_led_busy,
  output logic o_led_data_ready_line,
  output logic o_led_term_green,
  output logic o_led_term_red
);

  typedef enum logic [1:0] {
    BGC_IDLE,
    BGC_INTEG,
    BGC_CONVERT
  } bgc_state_type;

  bgc_state_type state;
  logic [BGC_SYNC_W-1:0] sync_in;
  logic [BGC_SYNC_W-1:0] sync_out;
  logic gate_front_s, gate_bus_s, veto_s, busy_line_s, data_ready_line_line_s;
  logic gate_eff, gate_q, gate_rise;
  logic veto_seen, own_busy, next_busy, halt;
  logic accept, reject, done_ev, data_ready_line_q;
  logic [7:0] tick_cnt;
  logic tick;
  logic [BGC_TIME_W-1:0] cfg_cnt, ack_cnt;
  logic configuring;
  logic [31:0] ctrl;
  logic [BGC_EV_W-1:0] int_stat, int_mask, events;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Input synchronisers
  // synchronise async inputs
  assign sync_in = {i_data_ready_line_line, i_busy_line, i_veto, i_gate_bus,
                    i_gate_front};
  bgc_sync #(
    .WIDTH(BGC_SYNC_W)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async(sync_in),
    .o_sync(sync_out)
  );
  assign {data_ready_line_line_s, busy_line_s, veto_s, gate_bus_s, gate_front_s} =
    sync_out;

  //////////////////////////////////////////////////////////////////////
  // Common gate and halt decision
  // gate OR combine
  assign gate_eff = gate_front_s | gate_bus_s;
  assign gate_rise = gate_eff & ~gate_q;
  assign halt = i_busy_scope_jumper ? (own_busy | busy_line_s) : own_busy;
  assign accept = (state == BGC_IDLE) & gate_rise & ~halt;
  assign reject = gate_rise & ~accept;
  assign done_ev = (state == BGC_CONVERT) & i_conv_done;

  //////////////////////////////////////////////////////////////////////
  // Acquisition sequence
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= BGC_IDLE;
      gate_q <= 1'b0;
      veto_seen <= 1'b0;
      o_conv_start <= 1'b0;
    end
    else
    begin
      gate_q <= gate_eff;
      o_conv_start <= 1'b0;
      case (state)
        BGC_IDLE:
        begin
          veto_seen <= 1'b0;
          if (accept)
            state <= BGC_INTEG;
        end
        BGC_INTEG:
        begin
          veto_seen <= veto_seen | veto_s;
          if (!gate_eff)
          begin
            if (veto_seen || veto_s)
              state <= BGC_IDLE;
            else
            begin
              state <= BGC_CONVERT;
              o_conv_start <= 1'b1;
            end
          end
        end
        BGC_CONVERT:
        begin
          if (i_conv_done)
            state <= BGC_IDLE;
        end
        default:
          state <= BGC_IDLE;
      endcase
    end
  end

  assign next_busy = (state != BGC_IDLE) | accept | i_analog_reset |
                     ctrl[BGC_CTRL_MEMTEST] | i_buffer_full;

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      own_busy <= 1'b0;
      o_conv_inhibit <= 1'b0;
    end
    else
    begin
      own_busy <= next_busy;
      o_conv_inhibit <= veto_s;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Channel gating
  genvar ch;
  generate
    for (ch = 0; ch < BGC_CHANNELS; ch = ch + 1)
    begin : g_chan
      always_ff @(posedge i_ref_clk or posedge i_rst)
      begin
        if (i_rst)
          o_chan_integrate[ch] <= 1'b0;
        else
          o_chan_integrate[ch] <= i_chan_gate[ch] & gate_eff &
                                  ((state == BGC_INTEG) | accept);
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Wired bus lines, driven while active and released otherwise
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_busy_pos <= 1'b1;
      o_busy_pos_oe_n <= 1'b1;
      o_busy_neg <= 1'b0;
      o_busy_neg_oe_n <= 1'b1;
      o_data_ready_line_pos <= 1'b1;
      o_data_ready_line_pos_oe_n <= 1'b1;
      o_data_ready_line_neg <= 1'b0;
      o_data_ready_line_neg_oe_n <= 1'b1;
    end
    else
    begin
      o_busy_pos_oe_n <= ~next_busy;
      o_busy_neg_oe_n <= ~next_busy;
      o_data_ready_line_pos_oe_n <= ~i_buffer_has_data;
      o_data_ready_line_neg_oe_n <= ~i_buffer_has_data;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Tick divider and power-on configuration
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tick_cnt <= 8'h00;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (tick_cnt == 8'(BGC_TICK_CYCLES - 1));
      if (tick_cnt == 8'(BGC_TICK_CYCLES - 1))
        tick_cnt <= 8'h00;
      else
        tick_cnt <= tick_cnt + 8'h01;
    end
  end

  assign configuring = (cfg_cnt != BGC_TIME_W'(CFG_TIME_US));

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      cfg_cnt <= '0;
    else if (configuring && tick)
      cfg_cnt <= cfg_cnt + BGC_TIME_W'(1);
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      o_base_addr <= '0;
    else if (configuring)
      o_base_addr <= i_rotary_sw;
  end

  //////////////////////////////////////////////////////////////////////
  // Front panel LEDs
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      ack_cnt <= '0;
    else if (i_bus_access)
      ack_cnt <= BGC_TIME_W'(ACK_TIME_US);
    else if (tick && ack_cnt != '0)
      ack_cnt <= ack_cnt - BGC_TIME_W'(1);
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_led_ack <= 1'b0;
      o_led_busy <= 1'b1;
      o_led_data_ready_line <= 1'b1;
      o_led_term_green <= 1'b1;
      o_led_term_red <= 1'b1;
    end
    else
    begin
      o_led_ack <= i_bus_access | (ack_cnt != '0);
      o_led_busy <= next_busy | configuring;
      o_led_data_ready_line <= i_buffer_has_data | configuring;
      o_led_term_green <= configuring | (&i_term_on);
      o_led_term_red <= configuring | ~(|i_term_on);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Registers and interrupt
  assign events = {i_buffer_has_data & ~data_ready_line_q, done_ev, reject, accept};

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl <= BGC_CTRL_RESET;
      int_mask <= BGC_MASK_RESET;
      int_stat <= '0;
      data_ready_line_q <= 1'b0;
    end
    else
    begin
      data_ready_line_q <= i_buffer_has_data;
      if (i_wr && hit(i_addr, BGC_ADDR_CTRL))
        ctrl <= {31'h0, i_wr_data[BGC_CTRL_MEMTEST]};
      if (i_wr && hit(i_addr, BGC_ADDR_INT_MASK))
        int_mask <= i_wr_data[BGC_EV_W-1:0];
      // Set wins over write-one clear
      if (i_wr && hit(i_addr, BGC_ADDR_INT_STAT))
        int_stat <= (int_stat & ~i_wr_data[BGC_EV_W-1:0]) | events;
      else
        int_stat <= int_stat | events;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rd_data <= 32'h0000_0000;
      o_irq <= 1'b0;
    end
    else
    begin
      o_irq <= |(int_stat & int_mask);
      o_rd_data <= 32'h0000_0000;
      if (i_rd)
      begin
        if (hit(i_addr, BGC_ADDR_STATUS))
        begin
          o_rd_data[BGC_ST_DATA_READY_LINE] <= i_buffer_has_data;
          o_rd_data[BGC_ST_DATA_READY_LINE_LINE] <= data_ready_line_line_s;
          o_rd_data[BGC_ST_BUSY] <= own_busy;
          o_rd_data[BGC_ST_GBUSY] <= busy_line_s;
        end
        else if (hit(i_addr, BGC_ADDR_CTRL))
          o_rd_data <= ctrl;
        else if (hit(i_addr, BGC_ADDR_INT_STAT))
          o_rd_data[BGC_EV_W-1:0] <= int_stat;
        else if (hit(i_addr, BGC_ADDR_INT_MASK))
          o_rd_data[BGC_EV_W-1:0] <= int_mask;
        else if (hit(i_addr, BGC_ADDR_BASE))
          o_rd_data[4*BGC_SWITCHES-1:0] <= o_base_addr;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  busy_on_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    accept |=> !o_busy_pos_oe_n && !o_busy_neg_oe_n)
    else $error("busy not driven after accepted gate");
  busy_source_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_buffer_full || i_analog_reset) |=> own_busy)
    else $error("busy missing for full buffer or reset");
  busy_release_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state == BGC_IDLE && !accept && !i_analog_reset && !i_buffer_full &&
     !ctrl[BGC_CTRL_MEMTEST]) |=> o_busy_pos_oe_n)
    else $error("busy line held while idle");
  ignore_busy_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (gate_rise && state != BGC_IDLE) |=>
      $stable(state) || $past(done_ev))
    else $error("gate accepted while busy");
  veto_block_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state == BGC_INTEG && veto_s) |-> ##1 !o_conv_start [*2])
    else $error("conversion started under veto");
  jumper_halt_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_busy_scope_jumper && busy_line_s && gate_rise) |-> !accept)
    else $error("gate accepted while bus busy");
  status_busy_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_rd && i_addr == BGC_ADDR_STATUS) |=>
      o_rd_data[BGC_ST_BUSY] == $past(own_busy))
    else $error("status busy bit wrong");
  chan_window_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !gate_eff |=> o_chan_integrate == '0)
    else $error("channel integrating outside gate");
  ack_led_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_bus_access |=> o_led_ack [*3])
    else $error("acknowledge LED missed access");
  term_led_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!configuring && i_term_on == '0) |=>
      o_led_term_red && !o_led_term_green)
    else $error("termination LED wrong with no lines");
  data_ready_line_line_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_buffer_has_data |=> !o_data_ready_line_pos_oe_n)
    else $error("data ready line not driven");

endmodule // bgc_busy_gate

`default_nettype wire

// >>> bgc_peer_model.sv
/*
  Far side model: peer boards on the wired busy and data ready lines,
  plus the converter that answers a start pulse with a done pulse.
  Assumes undriven lines settle low through the bus termination.
*/
`timescale 1ns/1ps
`default_nettype none

module bgc_peer_model #(
  parameter int CONV_CYCLES = 4
) (
  // Clock
  input wire logic i_ref_clk,
  // Board drive enables and converter start
  input wire logic i_busy_oe_n,
  input wire logic i_data_ready_line_oe_n,
  input wire logic i_conv_start,
  // Peer boards
  input wire logic i_peer_busy,
  input wire logic i_peer_data_ready_line,
  // Resolved lines and converter answer
  output logic o_busy_line,
  output logic o_data_ready_line_line,
  output logic o_conv_done
);
  int cnt = 0;

  assign o_busy_line = ~i_busy_oe_n | i_peer_busy;
  assign o_data_ready_line_line = ~i_data_ready_line_oe_n | i_peer_data_ready_line;

  // Conversion takes a fixed time
  always @(posedge i_ref_clk)
  begin
    if (i_conv_start)
      cnt <= CONV_CYCLES;
    else if (cnt > 0)
      cnt <= cnt - 1;
    o_conv_done <= (cnt == 1);
  end
endmodule // bgc_peer_model

`default_nettype wire

// >>> bgc_busy_gate_tb.sv
/*
  Self-checking bench for the busy and gate control block.
  Assumes shortened tick counts and the peer model on the bus lines.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); \
  end end

module bgc_busy_gate_tb
  import bgc_pkg::*;
;
  logic i_ref_clk, i_rst, i_wr, i_rd, i_gate_front, i_gate_bus, i_veto;
  logic i_busy_line, i_data_ready_line_line, i_conv_done, i_analog_reset;
  logic i_buffer_full, i_buffer_has_data, i_busy_scope_jumper, i_bus_access;
  logic peer_busy, peer_data_ready_line;
  logic [7:0] i_addr;
  logic [31:0] i_wr_data, o_rd_data, i_chan_gate, o_chan_integrate;
  logic [15:0] i_rotary_sw, o_base_addr, sw;
  logic [6:0] i_term_on;
  logic o_irq, o_busy_pos, o_busy_pos_oe_n, o_busy_neg, o_busy_neg_oe_n;
  logic o_data_ready_line_pos, o_data_ready_line_pos_oe_n, o_data_ready_line_neg, o_data_ready_line_neg_oe_n;
  logic o_conv_start, o_conv_inhibit, o_led_ack, o_led_busy, o_led_data_ready_line;
  logic o_led_term_green, o_led_term_red;
  logic [3:0] m_mask;
  logic [6:0] terms [3] = '{7'h7f, 7'h00, 7'h15};
  logic [1:0] tled [3] = '{2'b10, 2'b01, 2'b00};
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  integer seed;

  bgc_busy_gate #(.CFG_TIME_US(3), .ACK_TIME_US(2)) u_bgc_busy_gate (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .o_irq(o_irq), .i_gate_front(i_gate_front), .i_gate_bus(i_gate_bus),
    .i_veto(i_veto), .i_chan_gate(i_chan_gate), .i_busy_line(i_busy_line),
    .i_data_ready_line_line(i_data_ready_line_line), .o_busy_pos(o_busy_pos),
    .o_busy_pos_oe_n(o_busy_pos_oe_n), .o_busy_neg(o_busy_neg),
    .o_busy_neg_oe_n(o_busy_neg_oe_n), .o_data_ready_line_pos(o_data_ready_line_pos),
    .o_data_ready_line_pos_oe_n(o_data_ready_line_pos_oe_n), .o_data_ready_line_neg(o_data_ready_line_neg),
    .o_data_ready_line_neg_oe_n(o_data_ready_line_neg_oe_n), .i_conv_done(i_conv_done),
    .i_analog_reset(i_analog_reset), .i_buffer_full(i_buffer_full),
    .i_buffer_has_data(i_buffer_has_data), .o_conv_start(o_conv_start),
    .o_conv_inhibit(o_conv_inhibit), .o_chan_integrate(o_chan_integrate),
    .i_busy_scope_jumper(i_busy_scope_jumper), .i_rotary_sw(i_rotary_sw),
    .i_term_on(i_term_on), .i_bus_access(i_bus_access),
    .o_base_addr(o_base_addr), .o_led_ack(o_led_ack),
    .o_led_busy(o_led_busy), .o_led_data_ready_line(o_led_data_ready_line),
    .o_led_term_green(o_led_term_green), .o_led_term_red(o_led_term_red)
  );

  bgc_peer_model u_bgc_peer_model (
    .i_ref_clk(i_ref_clk), .i_busy_oe_n(o_busy_pos_oe_n),
    .i_data_ready_line_oe_n(o_data_ready_line_pos_oe_n), .i_conv_start(o_conv_start),
    .i_peer_busy(peer_busy), .i_peer_data_ready_line(peer_data_ready_line),
    .o_busy_line(i_busy_line), .o_data_ready_line_line(i_data_ready_line_line),
    .o_conv_done(i_conv_done)
  );

  initial
  begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      end_sim();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(o_rd_data, e);
  endtask

  function automatic logic [31:0] st(logic b, logic bl, logic dl, logic d);
    return {28'h0, bl, b, dl, d};
  endfunction

  // Model of one gate: accepted or refused, vetoed or converted
  task automatic do_gate(input logic f, input logic b, input logic v,
                         input logic acc);
    logic [31:0] ch;
    logic [3:0] ev;
    int n;
    ch = $random(seed);
    ev = acc ? (v ? 4'h1 : 4'h5) : 4'h2;
    n = 0;
    @(posedge i_ref_clk);
    i_chan_gate <= ch;
    i_gate_front <= f;
    i_gate_bus <= b;
    i_veto <= v;
    tick(1);
    if (acc)
      `CHK(o_busy_pos_oe_n, 1'b1);
    tick(5);
    `CHK(o_chan_integrate, acc ? ch : 32'h0);
    `CHK(o_conv_inhibit, v);
    if (acc)
    begin
      `CHK(o_busy_pos_oe_n, 1'b0);
      `CHK({o_busy_neg_oe_n, o_busy_neg}, 2'b00);
    end
    @(posedge i_ref_clk);
    i_gate_front <= 1'b0;
    i_gate_bus <= 1'b0;
    i_veto <= 1'b0;
    repeat (40)
    begin
      tick(1);
      if (o_conv_start === 1'b1)
        n++;
    end
    `CHK(n, (acc && !v) ? 1 : 0);
    if (acc)
      `CHK(o_busy_pos_oe_n, 1'b1);
    rdchk(BGC_ADDR_INT_STAT, {28'h0, ev});
    `CHK(o_irq, |(ev & m_mask));
    wr(BGC_ADDR_INT_STAT, 32'hf);
    rdchk(BGC_ADDR_INT_STAT, 32'h0);
    `CHK(o_irq, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'hae7d;
    {i_wr, i_rd, i_gate_front, i_gate_bus, i_veto, i_analog_reset} = '0;
    {i_buffer_full, i_buffer_has_data, i_busy_scope_jumper} = '0;
    {i_bus_access, peer_busy, peer_data_ready_line} = '0;
    i_addr = '0;
    i_wr_data = '0;
    i_chan_gate = '0;
    i_term_on = 7'h7f;
    sw = 16'($random(seed));
    i_rotary_sw = sw;
    i_rst = 1'b1;
    tick(2);
    `CHK({o_led_busy, o_led_data_ready_line}, 2'b11);
    `CHK(o_busy_pos_oe_n, 1'b1);
    i_rst <= 1'b0;
    tick(10);
    `CHK({o_led_term_green, o_led_term_red}, 2'b11);
    `CHK(o_base_addr, sw);
    tick(400);
    i_rotary_sw <= ~sw;
    rdchk(BGC_ADDR_BASE, {16'h0, sw});
    `CHK({o_led_busy, o_led_data_ready_line}, 2'b00);
    foreach (terms[k])
    begin
      i_term_on <= terms[k];
      tick(4);
      `CHK({o_led_term_green, o_led_term_red}, tled[k]);
    end
    rdchk(BGC_ADDR_CTRL, BGC_CTRL_RESET);
    rdchk(BGC_ADDR_INT_MASK, {28'h0, BGC_MASK_RESET});
    rdchk(8'h20, 32'h0);
    $display("test reset and settings done");
    @(posedge i_ref_clk);
    i_bus_access <= 1'b1;
    @(posedge i_ref_clk);
    i_bus_access <= 1'b0;
    tick(2);
    `CHK(o_led_ack, 1'b1);
    tick(260);
    `CHK(o_led_ack, 1'b0);
    $display("test ack led done");
    m_mask = 4'h2;
    wr(BGC_ADDR_INT_MASK, {28'h0, m_mask});
    rdchk(BGC_ADDR_INT_MASK, {28'h0, m_mask});
    do_gate(1'b1, 1'b0, 1'b0, 1'b1);
    do_gate(1'b0, 1'b1, 1'b0, 1'b1);
    do_gate(1'b1, 1'b1, 1'b1, 1'b1);
    $display("test gates done");
    i_busy_scope_jumper <= 1'b1;
    peer_busy <= 1'b1;
    tick(4);
    rdchk(BGC_ADDR_STATUS, st(1'b0, 1'b1, 1'b0, 1'b0));
    do_gate(1'b1, 1'b0, 1'b0, 1'b0);
    i_busy_scope_jumper <= 1'b0;
    do_gate(1'b1, 1'b0, 1'b0, 1'b1);
    peer_busy <= 1'b0;
    $display("test jumper done");
    for (int k = 0; k < 3; k++)
    begin
      if (k == 0)
        wr(BGC_ADDR_CTRL, 32'h1);
      i_analog_reset <= (k == 1);
      i_buffer_full <= (k == 2);
      tick(4);
      `CHK(o_led_busy, 1'b1);
      rdchk(BGC_ADDR_STATUS, st(1'b1, 1'b1, 1'b0, 1'b0));
      do_gate(1'b1, 1'b0, 1'b0, 1'b0);
      wr(BGC_ADDR_CTRL, 32'h0);
      i_analog_reset <= 1'b0;
      i_buffer_full <= 1'b0;
      tick(4);
      `CHK(o_busy_pos_oe_n, 1'b1);
    end
    $display("test busy sources done");
    // Second gate edge while converting is refused
    @(posedge i_ref_clk);
    i_gate_front <= 1'b1;
    tick(8);
    i_gate_front <= 1'b0;
    tick(4);
    i_gate_bus <= 1'b1;
    tick(30);
    i_gate_bus <= 1'b0;
    tick(4);
    rdchk(BGC_ADDR_INT_STAT, 32'h7);
    `CHK(o_irq, 1'b1);
    wr(BGC_ADDR_INT_STAT, 32'hf);
    $display("test gate during conversion done");
    i_buffer_has_data <= 1'b1;
    tick(4);
    rdchk(BGC_ADDR_STATUS, st(1'b0, 1'b0, 1'b1, 1'b1));
    `CHK({o_data_ready_line_pos_oe_n, o_data_ready_line_neg_oe_n}, 2'b00);
    `CHK({o_busy_pos, o_data_ready_line_pos, o_data_ready_line_neg}, 3'b110);
    `CHK(o_led_data_ready_line, 1'b1);
    rdchk(BGC_ADDR_INT_STAT, 32'h8);
    wr(BGC_ADDR_INT_STAT, 32'hf);
    i_buffer_has_data <= 1'b0;
    tick(4);
    `CHK(o_led_data_ready_line, 1'b0);
    $display("test data ready done");
    end_sim();
  end
endmodule // bgc_busy_gate_tb

`default_nettype wire
